// file: common/rx_line_defines.svh
`ifndef RX_LINE_DEFINES_SVH
`define RX_LINE_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define COND_STATUS_OFS 8'h10
`define IRQ_STATUS_OFS 8'h14
`define IRQ_ENABLE_OFS 8'h18
`define IRQ_CLEAR_OFS 8'h1C

// ************************************************************
// field positions and reset values
// ************************************************************
`define LEVEL_HI_BIT 7
`define LEVEL_LO_BIT 6
`define JITTER_BIT 5
`define CLK_LOST_BIT 4
`define CARRIER_BIT 3
`define IRQ_JITTER_BIT 0
`define IRQ_CLK_LOST_BIT 1
`define IRQ_CARRIER_BIT 2
`define IRQ_COUNT 3
`define IRQ_RESET 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ************************************************************
// timing and thresholds
// ************************************************************
`define CLK_PERIOD_NS 10
`define CLK_LOSS_NS 3000
`define CLK_LOSS_CYCLES (`CLK_LOSS_NS / `CLK_PERIOD_NS)
`define ZERO_RUN_LIMIT 8'hC0
`define ONES_WINDOW 112
`define ONES_NEEDED 7'h0E
`define JA_MARGIN 8'h04
`define JA_DEPTH_SHORT 8'h20
`define JA_DEPTH_LONG 8'h80
`define LEVEL_STEP1 7'h0F
`define LEVEL_STEP2 7'h1E
`define LEVEL_STEP3 7'h2D

`endif

// file: common/rx_line_pkg.sv
`default_nettype none
package rx_line_pkg;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

    typedef struct packed {
        logic rx_level_upper_bit;
        logic rx_level_lower_bit;
        logic jitter_fifo_near_limit;
        logic recv_clock_lost;
        logic framer_carrier_lost;
    } cond_t;

endpackage
`default_nettype wire

// file: hw/zero_run_carrier_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_line_defines.svh"

module zero_run_carrier_monitor (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic bit_valid, // one received bit this cycle
    input wire logic pos_bit, // positive rail sample
    input wire logic neg_bit, // negative rail sample
    output logic carrier_lost // framer carrier loss flag
);
    logic ones_bit;
    logic [`ONES_WINDOW-1:0] hist_ff;
    logic [6:0] ones_cnt_ff;
    logic [6:0] nxt_ones_cnt;
    logic [7:0] zero_run_ff;
    logic lost_ff;

    assign ones_bit = pos_bit | neg_bit;
    assign carrier_lost = lost_ff;

    // ************************************************************
    // ones density over a sliding window
    // ************************************************************
    always_comb begin
        nxt_ones_cnt = ones_cnt_ff;
        if (bit_valid) begin
            nxt_ones_cnt = ones_cnt_ff + 7'(ones_bit)
                - 7'(hist_ff[`ONES_WINDOW-1]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hist_ff <= '0;
            ones_cnt_ff <= 7'h00;
        end else begin
            ones_cnt_ff <= nxt_ones_cnt;
            if (bit_valid) begin
                hist_ff <= {hist_ff[`ONES_WINDOW-2:0], ones_bit};
            end
        end
    end

    // ************************************************************
    // consecutive zero run, saturating so it cannot wrap
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zero_run_ff <= 8'h00;
        end else if (bit_valid) begin
            if (ones_bit) begin
                zero_run_ff <= 8'h00;
            end else if (zero_run_ff != `ZERO_RUN_LIMIT) begin
                zero_run_ff <= zero_run_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lost_ff <= 1'b0;
        end else if (bit_valid && !ones_bit
                     && zero_run_ff == `ZERO_RUN_LIMIT - 8'h01) begin
            lost_ff <= 1'b1; // R5
        end else if (lost_ff && nxt_ones_cnt >= `ONES_NEEDED) begin
            lost_ff <= 1'b0; // R6
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    carrier_set_a: assert property ( // R5
        bit_valid && !ones_bit && zero_run_ff == 8'hBF |=> lost_ff)
        else $error("carrier loss not flagged after zero run");
    carrier_rise_a: assert property ( // R5
        $rose(lost_ff) |-> zero_run_ff == `ZERO_RUN_LIMIT)
        else $error("carrier loss flagged before full zero run");
    carrier_clear_a: assert property ( // R6
        $fell(lost_ff) |-> ones_cnt_ff >= `ONES_NEEDED)
        else $error("carrier loss cleared without ones density");

endmodule
`default_nettype wire

// file: hw/rx_line_condition_status.sv
// Overview of operation
// R1 - level indication: upper bit at register bit 7, lower at bit 6
// R2 - level code 00 above -7.5, 01 to -15, 10 to -22.5, 11 below
// R3 - jitter trip flag bit 5 when fifo within 4 bits of limit
// R4 - clock loss flag bit 4 after 3 us or more without clock edge
// R5 - carrier loss flag bit 3 after 192 consecutive zero bits
// R6 - carrier loss clears once 14 ones seen within 112 bits
// R7 - bits 2 to 0 unassigned; host must mask them out
// R8 - status register sits at offset 0x10, eight bits wide
// R9 - status register is read-only; writes change no flag
`timescale 1ns/1ps
`default_nettype none
`include "rx_line_defines.svh"

module rx_line_condition_status (
    input wire logic aclk, // system clock, 100 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic recv_clock_input, // recovered receive clock
    input wire logic recv_positive_data_in, // positive rail data
    input wire logic recv_negative_data_in, // negative rail data
    input wire logic [6:0] rx_atten_half_db, // line loss, 0.5 dB units
    input wire logic [7:0] jitter_fifo_fill, // attenuator fifo fill
    input wire logic jitter_fifo_long, // 1: 128-bit fifo, 0: 32-bit
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic irq // level interrupt, active high
);
    rx_line_pkg::wr_state_t wr_state_ff;
    rx_line_pkg::rd_state_t rd_state_ff;
    rx_line_pkg::cond_t cond_ff;
    rx_line_pkg::cond_t nxt_cond;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic have_aw_ff, have_w_ff;
    logic [7:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_hs, w_hs, ar_hs, wr_go;
    logic [7:0] wr_addr_eff;
    logic [31:0] wr_data_eff;
    logic [3:0] wr_strb_eff;
    logic rclk_prev_ff, rclk_edge, rclk_rise;
    logic [8:0] loss_cnt_ff, nxt_loss_cnt;
    logic carrier_lost;
    logic [7:0] ja_depth;
    logic [1:0] level_code;
    logic [`IRQ_COUNT-1:0] evt, irq_clr;
    logic [`IRQ_COUNT-1:0] irq_status_ff, irq_enable_ff;
    logic irq_ff;

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign irq = irq_ff;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr == `COND_STATUS_OFS)
            || (addr == `IRQ_STATUS_OFS)
            || (addr == `IRQ_ENABLE_OFS)
            || (addr == `IRQ_CLEAR_OFS);
    endfunction

    function automatic logic [1:0] level_encode(input logic [6:0] atten);
        if (atten >= `LEVEL_STEP3) begin
            level_encode = 2'h3;
        end else if (atten >= `LEVEL_STEP2) begin
            level_encode = 2'h2;
        end else if (atten >= `LEVEL_STEP1) begin
            level_encode = 2'h1;
        end else begin
            level_encode = 2'h0;
        end
    endfunction

    // ************************************************************
    // receive clock watch
    // ************************************************************
    // the receive clock is only sampled, so edges closer than one
    // system cycle apart are not resolved; fine for a 1.544 MHz line
    assign rclk_edge = recv_clock_input ^ rclk_prev_ff;
    assign rclk_rise = recv_clock_input & ~rclk_prev_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rclk_prev_ff <= 1'b0;
        end else begin
            rclk_prev_ff <= recv_clock_input;
        end
    end

    always_comb begin
        nxt_loss_cnt = loss_cnt_ff;
        if (rclk_edge) begin
            nxt_loss_cnt = 9'h000; // R4
        end else if (loss_cnt_ff < 9'(`CLK_LOSS_CYCLES)) begin
            nxt_loss_cnt = loss_cnt_ff + 9'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loss_cnt_ff <= 9'h000;
        end else begin
            loss_cnt_ff <= nxt_loss_cnt;
        end
    end

    // ************************************************************
    // carrier loss from the rail data
    // ************************************************************
    zero_run_carrier_monitor u_carrier (
        .aclk(aclk),
        .aresetn(aresetn),
        .bit_valid(rclk_rise),
        .pos_bit(recv_positive_data_in),
        .neg_bit(recv_negative_data_in),
        .carrier_lost(carrier_lost)
    );

    // ************************************************************
    // condition register
    // ************************************************************
    assign ja_depth = jitter_fifo_long ? `JA_DEPTH_LONG : `JA_DEPTH_SHORT;

    assign level_code = level_encode(rx_atten_half_db); // R2

    // flags come only from the detectors, so no bus write reaches them
    always_comb begin
        nxt_cond.rx_level_upper_bit = level_code[1];
        nxt_cond.rx_level_lower_bit = level_code[0];
        // trip near either end: overrun and underrun both matter
        nxt_cond.jitter_fifo_near_limit =
            (jitter_fifo_fill >= ja_depth - `JA_MARGIN)
            || (jitter_fifo_fill <= `JA_MARGIN); // R3
        nxt_cond.recv_clock_lost =
            (nxt_loss_cnt >= 9'(`CLK_LOSS_CYCLES)); // R4
        nxt_cond.framer_carrier_lost = carrier_lost; // R5 R6
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_ff <= '0;
        end else begin
            cond_ff <= nxt_cond; // R1 R2 R9
        end
    end

    // ************************************************************
    // interrupt status, enable and clear
    // ************************************************************
    assign evt[`IRQ_JITTER_BIT] = nxt_cond.jitter_fifo_near_limit
        & ~cond_ff.jitter_fifo_near_limit;
    assign evt[`IRQ_CLK_LOST_BIT] = nxt_cond.recv_clock_lost
        & ~cond_ff.recv_clock_lost;
    assign evt[`IRQ_CARRIER_BIT] = nxt_cond.framer_carrier_lost
        & ~cond_ff.framer_carrier_lost;
    assign irq_clr = (wr_go && wr_addr_eff == `IRQ_CLEAR_OFS
        && wr_strb_eff[0]) ? wr_data_eff[`IRQ_COUNT-1:0] : `IRQ_RESET;

    // a new event beats a clear landing in the same cycle
    generate
        for (genvar i = 0; i < `IRQ_COUNT; i++) begin : g_sticky
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    irq_status_ff[i] <= 1'b0;
                end else begin
                    irq_status_ff[i] <= evt[i]
                        | (irq_status_ff[i] & ~irq_clr[i]);
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_ff <= `IRQ_RESET;
        end else if (wr_go && wr_addr_eff == `IRQ_ENABLE_OFS
                     && wr_strb_eff[0]) begin
            irq_enable_ff <= wr_data_eff[`IRQ_COUNT-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_enable_ff);
        end
    end

    // ************************************************************
    // write channels
    // ************************************************************
    assign aw_hs = awvalid & awready_ff;
    assign w_hs = wvalid & wready_ff;
    assign wr_addr_eff = aw_hs ? awaddr : waddr_ff;
    assign wr_data_eff = w_hs ? wdata : wdata_ff;
    assign wr_strb_eff = w_hs ? wstrb : wstrb_ff;
    assign wr_go = (wr_state_ff == rx_line_pkg::WR_COLLECT)
        && (have_aw_ff || aw_hs) && (have_w_ff || w_hs);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= rx_line_pkg::WR_COLLECT;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            have_aw_ff <= 1'b0;
            have_w_ff <= 1'b0;
            waddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else begin
            case (wr_state_ff)
                rx_line_pkg::WR_COLLECT: begin
                    if (aw_hs) begin
                        have_aw_ff <= 1'b1;
                        waddr_ff <= awaddr;
                    end
                    if (w_hs) begin
                        have_w_ff <= 1'b1;
                        wdata_ff <= wdata;
                        wstrb_ff <= wstrb;
                    end
                    awready_ff <= !(have_aw_ff || aw_hs);
                    wready_ff <= !(have_w_ff || w_hs);
                    if (wr_go) begin
                        wr_state_ff <= rx_line_pkg::WR_RESP;
                        awready_ff <= 1'b0;
                        wready_ff <= 1'b0;
                        bvalid_ff <= 1'b1;
                        // read-only offsets answer okay and store nothing
                        bresp_ff <= addr_mapped(wr_addr_eff)
                            ? `RESP_OKAY : `RESP_SLVERR; // R9
                    end
                end
                rx_line_pkg::WR_RESP: begin
                    if (bready) begin
                        wr_state_ff <= rx_line_pkg::WR_COLLECT;
                        bvalid_ff <= 1'b0;
                        have_aw_ff <= 1'b0;
                        have_w_ff <= 1'b0;
                        awready_ff <= 1'b1;
                        wready_ff <= 1'b1;
                    end
                end
                default: begin
                    wr_state_ff <= rx_line_pkg::WR_COLLECT;
                end
            endcase
        end
    end

    // ************************************************************
    // read channels
    // ************************************************************
    assign ar_hs = arvalid & arready_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= rx_line_pkg::RD_IDLE;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_OKAY;
        end else begin
            case (rd_state_ff)
                rx_line_pkg::RD_IDLE: begin
                    arready_ff <= 1'b1;
                    if (ar_hs) begin
                        rd_state_ff <= rx_line_pkg::RD_DATA;
                        arready_ff <= 1'b0;
                        rvalid_ff <= 1'b1;
                        rdata_ff <= 32'h0000_0000;
                        rresp_ff <= addr_mapped(araddr)
                            ? `RESP_OKAY : `RESP_SLVERR;
                        case (araddr)
                            `COND_STATUS_OFS: begin // R8
                                // unassigned low bits read as zero
                                rdata_ff[`LEVEL_HI_BIT] <=
                                    cond_ff.rx_level_upper_bit; // R1
                                rdata_ff[`LEVEL_LO_BIT] <=
                                    cond_ff.rx_level_lower_bit; // R1
                                rdata_ff[`JITTER_BIT] <=
                                    cond_ff.jitter_fifo_near_limit;
                                rdata_ff[`CLK_LOST_BIT] <=
                                    cond_ff.recv_clock_lost;
                                rdata_ff[`CARRIER_BIT] <=
                                    cond_ff.framer_carrier_lost; // R5
                            end
                            `IRQ_STATUS_OFS: begin
                                rdata_ff[`IRQ_COUNT-1:0] <= irq_status_ff;
                            end
                            `IRQ_ENABLE_OFS: begin
                                rdata_ff[`IRQ_COUNT-1:0] <= irq_enable_ff;
                            end
                            default: begin
                                rdata_ff <= 32'h0000_0000;
                            end
                        endcase
                    end
                end
                rx_line_pkg::RD_DATA: begin
                    if (rready) begin
                        rd_state_ff <= rx_line_pkg::RD_IDLE;
                        rvalid_ff <= 1'b0;
                        arready_ff <= 1'b1;
                    end
                end
                default: begin
                    rd_state_ff <= rx_line_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence status_read_s;
        arvalid && arready_ff && araddr == `COND_STATUS_OFS;
    endsequence

    sequence status_answer_s;
        rvalid_ff && rresp_ff == 2'h0 && rdata_ff[31:8] == 24'h0
            && rdata_ff[2:0] == 3'h0;
    endsequence

    level_low_a: assert property ( // R2
        rx_atten_half_db < 7'h0F |=> !cond_ff.rx_level_upper_bit
            && !cond_ff.rx_level_lower_bit)
        else $error("strong line not coded 00");
    level_high_a: assert property ( // R2
        rx_atten_half_db >= 7'h2D |=> cond_ff.rx_level_upper_bit
            && cond_ff.rx_level_lower_bit)
        else $error("weak line not coded 11");
    level_read_a: assert property ( // R1
        status_read_s |=>
            rdata_ff[7] == $past(cond_ff.rx_level_upper_bit)
            && rdata_ff[6] == $past(cond_ff.rx_level_lower_bit))
        else $error("level bits misplaced in read word");
    status_map_a: assert property ( // R8
        status_read_s |=> status_answer_s)
        else $error("status read wrong answer or stray bits");
    jitter_trip_a: assert property ( // R3
        jitter_fifo_long && jitter_fifo_fill >= 8'h7C
            |=> cond_ff.jitter_fifo_near_limit)
        else $error("jitter trip missed near limit");
    jitter_quiet_a: assert property ( // R3
        !jitter_fifo_long && jitter_fifo_fill > 8'h04
            && jitter_fifo_fill < 8'h1C |=> !cond_ff.jitter_fifo_near_limit)
        else $error("jitter trip away from limits");
    clk_loss_min_a: assert property ( // R4
        $rose(cond_ff.recv_clock_lost) |-> loss_cnt_ff >= 9'h0C8)
        else $error("clock loss flagged before 2 us");
    clk_loss_end_a: assert property ( // R4
        rclk_edge |=> !cond_ff.recv_clock_lost)
        else $error("clock loss held despite clock edge");
    write_ignored_a: assert property ( // R9
        wr_go && wr_addr_eff == `COND_STATUS_OFS
            |=> cond_ff == $past(nxt_cond) && bresp_ff == 2'h0)
        else $error("status write disturbed flags");
    irq_raise_a: assert property (
        |(evt & irq_enable_ff) ##1 |(irq_status_ff & irq_enable_ff)
            |=> irq_ff)
        else $error("enabled event did not raise interrupt");

endmodule
`default_nettype wire

// file: sim/rx_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// receive line model: four aclk cycles per bit
// ****
module rx_line_partner (
    input wire logic aclk, // system clock
    input wire logic run, // high: line clock toggles
    input wire logic ones, // high: a mark on every eighth bit
    output logic rclk, // recovered line clock
    output logic pos, // positive rail
    output logic neg // negative rail
);
    logic [1:0] ph_ff;
    logic [2:0] bit_ff;
    logic pol_ff;
    initial begin
        {ph_ff, bit_ff, pol_ff, rclk, pos, neg} = 9'h000;
    end
    always @(posedge aclk) begin
        if (run) begin
            ph_ff <= ph_ff + 2'h1;
            rclk <= ph_ff[1];
            if (ph_ff == 2'h0) begin
                bit_ff <= bit_ff + 3'h1;
                pos <= ones && bit_ff == 3'h7 && pol_ff;
                neg <= ones && bit_ff == 3'h7 && !pol_ff;
                pol_ff <= pol_ff ^ (ones && bit_ff == 3'h7);
            end
        end else begin
            // clock stands still: rails wander so no stale level is trusted
            pos <= ~pos;
            neg <= ~neg;
        end
    end
endmodule
`default_nettype wire

// file: sim/rx_line_condition_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rx_line_condition_status_tb;
    typedef struct packed {
        logic [1:0] r;
        logic [31:0] d;
        logic [31:0] m;
    } note_t;
    logic aclk, aresetn, run, ones, rclk, pos, neg, long_fifo, irq;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [6:0] atten;
    logic [7:0] fill, awaddr, araddr;
    logic [31:0] wdata, rdata, seed, exp_word;
    logic [1:0] bresp, rresp;
    int mismatches, num_checks;
    note_t expq[$];
    rx_line_partner line_u (.aclk(aclk), .run(run), .ones(ones),
        .rclk(rclk), .pos(pos), .neg(neg));
    rx_line_condition_status dut_u (.aclk(aclk), .aresetn(aresetn),
        .recv_clock_input(rclk), .recv_positive_data_in(pos),
        .recv_negative_data_in(neg), .rx_atten_half_db(atten),
        .jitter_fifo_fill(fill), .jitter_fifo_long(long_fifo),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    // ****
    // bus master: requests held until sampled ready
    // ****
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m,
            logic [1:0] r);
        expq.push_back('{r, e, m});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
        logic aw, w;
        {aw, w} = 2'h0;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | (awready === 1'b1);
            w = w | (wready === 1'b1);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, bresp});
        @(posedge aclk);
    endtask
    // host masks the unassigned low bits of every status read
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            note_t n;
            n = expq.pop_front();
            chk("rresp", {30'h0, n.r}, {30'h0, rresp});
            chk("rdata", n.d & n.m, rdata & n.m);
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        complete_run();
    end
    initial begin
        seed = 32'hDC7C5E8A;
        {aresetn, ones, long_fifo, awvalid, wvalid} = 5'h0;
        {bready, arvalid, rready, run} = 4'h1;
        {atten, awaddr, araddr, wdata} = '0;
        fill = 8'h10;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            atten <= 7'(15 * i + xs() % 15);
            long_fifo <= i[1];
            fill <= (i[1] ? 8'h7C : 8'h1C) - {7'h0, i[0]};
            repeat (3) @(posedge aclk);
            exp_word = {24'h0, 2'(i), !i[0], 5'h0};
            rd(8'h10, exp_word, 32'hFFFFFFF8, 2'h0);
        end
        fill <= 8'h10;
        $display("level and jitter test done");
        wr(8'h10, 32'hFF, 2'h0);
        rd(8'h10, 32'hC0, 32'hFFFFFFF8, 2'h0);
        rd(8'h40, 32'h0, 32'hFFFFFFFF, 2'h2);
        wr(8'h40, 32'h7, 2'h2);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF, 2'h0);
        $display("register access test done");
        ones <= 1'b1;
        repeat (32) @(posedge aclk);
        ones <= 1'b0;
        repeat (680) @(posedge aclk);
        rd(8'h10, 32'hC0, 32'hFFFFFFF8, 2'h0);
        repeat (120) @(posedge aclk);
        rd(8'h10, 32'hC8, 32'hFFFFFFF8, 2'h0);
        ones <= 1'b1;
        repeat (400) @(posedge aclk);
        rd(8'h10, 32'hC8, 32'hFFFFFFF8, 2'h0);
        repeat (100) @(posedge aclk);
        rd(8'h10, 32'hC0, 32'hFFFFFFF8, 2'h0);
        $display("carrier loss test done");
        wr(8'h18, 32'h7, 2'h0);
        wr(8'h1C, 32'h7, 2'h0);
        chk("irq", 32'h0, {31'h0, irq});
        run <= 1'b0;
        repeat (150) @(posedge aclk);
        rd(8'h10, 32'hC0, 32'hFFFFFFF8, 2'h0);
        repeat (160) @(posedge aclk);
        rd(8'h10, 32'hD0, 32'hFFFFFFF8, 2'h0);
        chk("irq", 32'h1, {31'h0, irq});
        rd(8'h14, 32'h2, 32'h7, 2'h0);
        wr(8'h18, 32'h0, 2'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h1C, 32'h2, 2'h0);
        wr(8'h18, 32'h7, 2'h0);
        repeat (3) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        rd(8'h14, 32'h0, 32'h7, 2'h0);
        run <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(8'h10, 32'hC0, 32'hFFFFFFF8, 2'h0);
        $display("clock loss and interrupt test done");
        complete_run();
    end
endmodule
`default_nettype wire
